//--- inc/rpi_cfg.svh
// Purpose: Constants for the reduced media independent interface port.
// Assumes: Included once per compile unit by bare name.
// Notes: Counts are in cycles of the reference clock clk.
`ifndef RPI_CFG_SVH
`define RPI_CFG_SVH

// ----------------------------------------------------------------------
// Line timing
// ----------------------------------------------------------------------
`define RPI_SLOW_HOLD_LAST 4'h9
`define RPI_DIV_ZERO 4'h0
`define RPI_DIV_ONE 4'h1

// ----------------------------------------------------------------------
// Dibit and byte framing
// ----------------------------------------------------------------------
`define RPI_DIBIT_LAST 2'h3
`define RPI_DIBIT_FIRST 2'h0
`define RPI_DIBIT_STEP 2'h1
`define RPI_DIBIT_IDLE 2'h0
`define RPI_PREAMBLE_DIBIT 2'h1
`define RPI_BYTE_ZERO 8'h00

// ----------------------------------------------------------------------
// Receive buffer word layout
// ----------------------------------------------------------------------
`define RPI_WORD_W 10
`define RPI_WORD_LAST_BIT 9
`define RPI_WORD_ERR_BIT 8

`endif

//--- inc/rpi_pkg.sv
// Purpose: Types shared by the reduced interface port files.
// Assumes: rpi_cfg.svh is on the include path.
// Notes: Holds types only; numbers live in the header.
`include "rpi_cfg.svh"

package rpi_pkg;
  typedef logic [1:0] rpi_dibit_t;
  typedef logic [7:0] rpi_byte_t;
  typedef logic [`RPI_WORD_W-1:0] rpi_word_t;
  typedef enum logic [1:0] {
    RPI_TX_IDLE,
    RPI_TX_SEND
  } rpi_tx_state_e;
  typedef enum logic [1:0] {
    RPI_RX_IDLE,
    RPI_RX_HUNT,
    RPI_RX_DATA
  } rpi_rx_state_e;
endpackage

//--- rtl/rpi_pair_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: The head entry is a register, so read data leave a flop.
`timescale 1ns/1ps
`include "rpi_cfg.svh"

module rpi_pair_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire rpi_pkg::rpi_word_t in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output rpi_pkg::rpi_word_t out_data
);
  import rpi_pkg::*;

  logic head_v_q, head_v_d, spare_v_q, spare_v_d;
  rpi_word_t head_q, head_d, spare_q, spare_d;
  logic push, pop;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Ready depends only on the spare slot, so a full buffer stalls the source.
  assign in_ready = !spare_v_q;
  assign push = in_valid && in_ready;
  assign pop = head_v_q && out_ready;
  assign out_valid = head_v_q;
  assign out_data = head_q;

  always_comb begin
    head_v_d = head_v_q;
    head_d = head_q;
    spare_v_d = spare_v_q;
    spare_d = spare_q;
    if (pop) begin
      head_v_d = spare_v_q;
      head_d = spare_q;
      spare_v_d = 1'b0;
    end
    if (push) begin
      if (!head_v_d) begin
        head_v_d = 1'b1;
        head_d = in_data;
      end else begin
        spare_v_d = 1'b1;
        spare_d = in_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
      head_q <= '0;
      spare_q <= '0;
    end else begin
      head_v_q <= head_v_d;
      spare_v_q <= spare_v_d;
      head_q <= head_d;
      spare_q <= spare_d;
    end
  end
endmodule // rpi_pair_buf

//--- rtl/rmii_port_interface.sv
// Purpose: Reduced media independent interface of the third switch port.
// Assumes: clk is the shared reference clock; pins are synchronous to it.
// Notes: Errored frames are flagged toward the core, which discards them.
`timescale 1ns/1ps
`include "rpi_cfg.svh"

module rmii_port_interface (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps and mode
  input wire logic ref_clock_drive_strap,
  input wire logic freq_select_strap,
  input wire logic speed_10_sel,
  input wire logic half_duplex_sel,
  output logic strap_error,
  // Clock pins
  input wire logic crystal_input,
  output logic crystal_output,
  output logic ref_clock_output_pin,
  // Pins toward the partner
  output logic receive_valid_out,
  output rpi_pkg::rpi_dibit_t rxd_out,
  // Pins from the partner
  input wire logic tx_en_in,
  input wire rpi_pkg::rpi_dibit_t txd_in,
  input wire logic tx_err_in,
  // Port MAC egress stream
  input wire logic mac_tx_valid,
  output logic mac_tx_ready,
  input wire rpi_pkg::rpi_byte_t mac_tx_data,
  input wire logic mac_tx_last,
  // Port MAC ingress stream
  output logic mac_rx_valid,
  input wire logic mac_rx_ready,
  output rpi_pkg::rpi_byte_t mac_rx_data,
  output logic mac_rx_last,
  output logic mac_rx_err,
  output logic collision
);
  import rpi_pkg::*;

  // ----------------------------------------------------------------------
  // Straps and reference clock
  // ----------------------------------------------------------------------
  logic sel_q, sel_d, strap_err_q, strap_err_d, refo_q, refo_d, xo_q, xo_d;

  always_comb begin
    sel_d = sys_rst ? freq_select_strap : sel_q;
    strap_err_d = ref_clock_drive_strap != sel_q;
    // The output only toggles in the one legal driving combination.
    refo_d = (ref_clock_drive_strap && sel_q) ? !refo_q : 1'b0;
    // With the strap low the crystal pins are idle and the input clock rules.
    xo_d = ref_clock_drive_strap ? !crystal_input : 1'b0;
  end

  always_ff @(posedge clk) begin
    sel_q <= sel_d;
    if (sys_rst) begin
      strap_err_q <= 1'b0;
      refo_q <= 1'b0;
      xo_q <= 1'b0;
    end else begin
      strap_err_q <= strap_err_d;
      refo_q <= refo_d;
      xo_q <= xo_d;
    end
  end

  assign strap_error = strap_err_q;
  assign ref_clock_output_pin = refo_q;
  assign crystal_output = xo_q;

  // ----------------------------------------------------------------------
  // Line pacing
  // ----------------------------------------------------------------------
  function automatic logic [3:0] div_next(input logic [3:0] cur, input logic slow);
    div_next = (!slow || cur == `RPI_SLOW_HOLD_LAST) ? `RPI_DIV_ZERO : cur + `RPI_DIV_ONE;
  endfunction

  function automatic logic is_lead(input rpi_dibit_t d);
    is_lead = d == `RPI_PREAMBLE_DIBIT;
  endfunction

  // ----------------------------------------------------------------------
  // Egress serialiser, core toward partner
  // ----------------------------------------------------------------------
  rpi_tx_state_e tx_st_q, tx_st_d;
  logic [3:0] tx_div_q, tx_div_d;
  logic tx_tick;
  rpi_byte_t sh_q, sh_d, nxt_q, nxt_d;
  logic nxt_v_q, nxt_v_d, nxt_last_q, nxt_last_d, cur_last_q, cur_last_d;
  logic [1:0] tx_idx_q, tx_idx_d;
  logic rv_q, rv_d, rdy_q, rdy_d, col_q, col_d;
  rpi_dibit_t rxd_q, rxd_d;

  assign tx_tick = tx_div_q == `RPI_DIV_ZERO;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_div_d = div_next(tx_div_q, speed_10_sel);
    sh_d = sh_q;
    nxt_d = nxt_q;
    nxt_v_d = nxt_v_q;
    nxt_last_d = nxt_last_q;
    cur_last_d = cur_last_q;
    tx_idx_d = tx_idx_q;
    rv_d = rv_q;
    rxd_d = rxd_q;
    if (rdy_q && mac_tx_valid) begin
      nxt_d = mac_tx_data;
      nxt_v_d = 1'b1;
      nxt_last_d = mac_tx_last;
    end
    if (tx_tick) begin
      case (tx_st_q)
        RPI_TX_IDLE: begin
          rv_d = 1'b0;
          rxd_d = `RPI_DIBIT_IDLE;
          if (nxt_v_q) begin
            tx_st_d = RPI_TX_SEND;
            rv_d = 1'b1;
            rxd_d = nxt_q[1:0];
            sh_d = nxt_q >> 2;
            cur_last_d = nxt_last_q;
            nxt_v_d = 1'b0;
            tx_idx_d = `RPI_DIBIT_STEP;
          end
        end
        RPI_TX_SEND: begin
          if (tx_idx_q != `RPI_DIBIT_FIRST) begin
            rxd_d = sh_q[1:0];
            sh_d = sh_q >> 2;
            tx_idx_d = tx_idx_q + `RPI_DIBIT_STEP;
          end else if (!cur_last_q && nxt_v_q) begin
            rxd_d = nxt_q[1:0];
            sh_d = nxt_q >> 2;
            cur_last_d = nxt_last_q;
            nxt_v_d = 1'b0;
            tx_idx_d = `RPI_DIBIT_STEP;
          end else begin
            // A late core byte ends the frame early; the far end sees a short frame.
            tx_st_d = RPI_TX_IDLE;
            rv_d = 1'b0;
            rxd_d = `RPI_DIBIT_IDLE;
          end
        end
        default: begin
          tx_st_d = RPI_TX_IDLE;
          rv_d = 1'b0;
          rxd_d = `RPI_DIBIT_IDLE;
        end
      endcase
    end
    rdy_d = !nxt_v_d;
    // No collision pin: transmit and carrier together in half duplex.
    col_d = half_duplex_sel && rv_q && tx_en_in;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st_q <= RPI_TX_IDLE;
      tx_div_q <= `RPI_DIV_ZERO;
      sh_q <= `RPI_BYTE_ZERO;
      nxt_q <= `RPI_BYTE_ZERO;
      nxt_v_q <= 1'b0;
      nxt_last_q <= 1'b0;
      cur_last_q <= 1'b0;
      tx_idx_q <= `RPI_DIBIT_FIRST;
      rv_q <= 1'b0;
      rxd_q <= `RPI_DIBIT_IDLE;
      rdy_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_div_q <= tx_div_d;
      sh_q <= sh_d;
      nxt_q <= nxt_d;
      nxt_v_q <= nxt_v_d;
      nxt_last_q <= nxt_last_d;
      cur_last_q <= cur_last_d;
      tx_idx_q <= tx_idx_d;
      rv_q <= rv_d;
      rxd_q <= rxd_d;
      rdy_q <= rdy_d;
      col_q <= col_d;
    end
  end

  assign receive_valid_out = rv_q;
  assign rxd_out = rxd_q;
  assign mac_tx_ready = rdy_q;
  assign collision = col_q;

  // ----------------------------------------------------------------------
  // Ingress deserialiser, partner toward core
  // ----------------------------------------------------------------------
  rpi_rx_state_e rx_st_q, rx_st_d;
  logic [3:0] rx_div_q, rx_div_d;
  rpi_byte_t as_q, as_d, pend_q, pend_d;
  logic [1:0] rx_idx_q, rx_idx_d;
  logic pend_v_q, pend_v_d, err_q, err_d, push;
  rpi_word_t push_word, pop_word;
  logic buf_ready, rx_tick;

  // Sampling restarts at each frame so slow-rate pairs are caught once.
  assign rx_tick = rx_div_q == `RPI_DIV_ZERO;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_div_d = tx_en_in ? div_next(rx_div_q, speed_10_sel) : `RPI_DIV_ZERO;
    as_d = as_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    rx_idx_d = rx_idx_q;
    err_d = err_q || (tx_en_in && tx_err_in);
    push = 1'b0;
    push_word = {1'b0, err_q, pend_q};
    case (rx_st_q)
      RPI_RX_IDLE: begin
        err_d = 1'b0;
        pend_v_d = 1'b0;
        if (tx_en_in) begin
          err_d = tx_err_in;
          // The pair that comes with the enable may already be the first data pair.
          if (is_lead(txd_in)) begin
            rx_st_d = RPI_RX_DATA;
            as_d = {txd_in, 6'h00};
            rx_idx_d = `RPI_DIBIT_STEP;
          end else begin
            rx_st_d = RPI_RX_HUNT;
          end
        end
      end
      RPI_RX_HUNT: begin
        if (!tx_en_in) begin
          rx_st_d = RPI_RX_IDLE;
        end else if (rx_tick && is_lead(txd_in)) begin
          rx_st_d = RPI_RX_DATA;
          as_d = {txd_in, 6'h00};
          rx_idx_d = `RPI_DIBIT_STEP;
        end
      end
      RPI_RX_DATA: begin
        if (!tx_en_in) begin
          rx_st_d = RPI_RX_IDLE;
          // A partial byte at frame end marks the frame errored.
          push = pend_v_q;
          push_word = {1'b1, err_q || rx_idx_q != `RPI_DIBIT_FIRST, pend_q};
        end else if (rx_tick) begin
          as_d = {txd_in, as_q[7:2]};
          rx_idx_d = rx_idx_q + `RPI_DIBIT_STEP;
          if (rx_idx_q == `RPI_DIBIT_LAST) begin
            push = pend_v_q;
            pend_d = {txd_in, as_q[7:2]};
            pend_v_d = 1'b1;
          end
        end
      end
      default: begin
        rx_st_d = RPI_RX_IDLE;
      end
    endcase
    // The wire cannot be stalled, so a refused byte before the last poisons the frame instead.
    if (push && !buf_ready) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st_q <= RPI_RX_IDLE;
      rx_div_q <= `RPI_DIV_ZERO;
      as_q <= `RPI_BYTE_ZERO;
      pend_q <= `RPI_BYTE_ZERO;
      pend_v_q <= 1'b0;
      rx_idx_q <= `RPI_DIBIT_FIRST;
      err_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_div_q <= rx_div_d;
      as_q <= as_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      rx_idx_q <= rx_idx_d;
      err_q <= err_d;
    end
  end

  rpi_pair_buf u_rx_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(push_word),
    .out_valid(mac_rx_valid),
    .out_ready(mac_rx_ready),
    .out_data(pop_word)
  );

  assign mac_rx_data = pop_word[7:0];
  assign mac_rx_err = pop_word[`RPI_WORD_ERR_BIT];
  assign mac_rx_last = pop_word[`RPI_WORD_LAST_BIT];
endmodule // rmii_port_interface

//--- sim/rpi_port_monitor.sv
// Purpose: Port-level checks of the reduced interface port.
// Assumes: Bound to rmii_port_interface; one clock, clk.
// Notes: Pace checks assume speed changes only between frames.
`timescale 1ns/1ps

module rpi_port_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps and clock pins
  input wire logic ref_clock_drive_strap,
  input wire logic speed_10_sel,
  input wire logic half_duplex_sel,
  input wire logic strap_error,
  input wire logic crystal_input,
  input wire logic crystal_output,
  input wire logic ref_clock_output_pin,
  // Link pins
  input wire logic receive_valid_out,
  input wire rpi_pkg::rpi_dibit_t rxd_out,
  input wire logic tx_en_in,
  input wire logic collision,
  // Core streams
  input wire logic mac_tx_valid,
  input wire logic mac_tx_ready,
  input wire logic mac_rx_valid,
  input wire logic mac_rx_ready,
  input wire rpi_pkg::rpi_byte_t mac_rx_data,
  input wire logic mac_rx_last,
  input wire logic mac_rx_err
);
  import rpi_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] p_q, p_d;
  logic arm_q, arm_d, chg;
  int unsigned ph_q, ph_d, vc_q, vc_d;
  // The phase counter only arms after a change seen at the slow rate.
  always_comb begin
    chg = {receive_valid_out, rxd_out} != p_q;
    p_d = sys_rst ? 3'h0 : {receive_valid_out, rxd_out};
    arm_d = !sys_rst && speed_10_sel && (arm_q || chg);
    ph_d = (sys_rst || chg || ph_q == 9) ? 0 : ph_q + 1;
    vc_d = (!sys_rst && receive_valid_out) ? vc_q + 1 : 0;
  end
  always_ff @(posedge clk) begin
    p_q <= p_d;
    arm_q <= arm_d;
    ph_q <= ph_d;
    vc_q <= vc_d;
  end
  chk_reset_quiet: assert property ($past(sys_rst) |->
    !receive_valid_out && !mac_rx_valid && !mac_tx_ready && !collision)
    else $error("outputs not idle after reset");
  chk_coll_late: assert property ($past(!sys_rst) |->
    collision == $past(half_duplex_sel & receive_valid_out & tx_en_in))
    else $error("collision flag wrong");
  chk_refclk_run: assert property (
    $past(ref_clock_drive_strap && !strap_error) && $past(!sys_rst, 2)
    |-> ref_clock_output_pin != $past(ref_clock_output_pin))
    else $error("reference clock output not toggling");
  chk_refclk_off: assert property (
    !ref_clock_drive_strap && $past(!ref_clock_drive_strap) |-> !ref_clock_output_pin)
    else $error("reference clock output driven while strap low");
  chk_xtal_inv: assert property ($past(ref_clock_drive_strap && !sys_rst) |->
    crystal_output == !$past(crystal_input))
    else $error("crystal output not inverse of input");
  chk_ready_drop: assert property (mac_tx_valid && mac_tx_ready |=> !mac_tx_ready)
    else $error("egress ready stayed high after take");
  chk_rx_hold: assert property (mac_rx_valid && !mac_rx_ready |=> mac_rx_valid &&
    $stable({mac_rx_data, mac_rx_last, mac_rx_err}))
    else $error("ingress word changed while stalled");
  chk_idle_pair: assert property (!receive_valid_out |-> rxd_out == 2'h0)
    else $error("data pair not zero while idle");
  chk_slow_pace: assert property (arm_q && speed_10_sel && chg |-> ph_q == 9)
    else $error("pair not held ten cycles");
  chk_frame_len: assert property (p_q[2] && !receive_valid_out |->
    vc_q % (speed_10_sel ? 40 : 4) == 0)
    else $error("frame not whole bytes of pairs");
  cov_coll: cover property (collision);
  cov_err_last: cover property (mac_rx_valid && mac_rx_last && mac_rx_err);
  cov_slow_tx: cover property (speed_10_sel && receive_valid_out);
  cov_strap: cover property (strap_error);
endmodule // rpi_port_monitor

bind rmii_port_interface rpi_port_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .ref_clock_drive_strap(ref_clock_drive_strap), .speed_10_sel(speed_10_sel),
  .half_duplex_sel(half_duplex_sel), .strap_error(strap_error),
  .crystal_input(crystal_input), .crystal_output(crystal_output),
  .ref_clock_output_pin(ref_clock_output_pin), .receive_valid_out(receive_valid_out),
  .rxd_out(rxd_out), .tx_en_in(tx_en_in), .collision(collision),
  .mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready), .mac_rx_valid(mac_rx_valid),
  .mac_rx_ready(mac_rx_ready), .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last),
  .mac_rx_err(mac_rx_err));

//--- sim/rpi_far_end.sv
// Purpose: Behavioural far-end PHY or MAC of the reduced interface.
// Assumes: Shares clk with the device; slow selects ten-cycle pairs.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/1ps

module rpi_far_end (
  // Clock and pace
  input wire logic clk,
  input wire logic slow,
  // Pins from the device
  input wire logic receive_valid_out,
  input wire rpi_pkg::rpi_dibit_t rxd_out,
  // Pins toward the device
  output logic tx_en_in,
  output rpi_pkg::rpi_dibit_t txd_in,
  output logic tx_err_in
);
  import rpi_pkg::*;
  rpi_byte_t got_q[$];
  rpi_byte_t sh = 8'h00;
  int ph = 0;
  int np = 0;
  initial begin
    tx_en_in = 1'b0;
    txd_in = 2'h2;
    tx_err_in = 1'b0;
  end
  // Pairs are sampled from the rise of valid, lowest pair first.
  always @(posedge clk) begin
    if (receive_valid_out) begin
      if (ph == 0) begin
        sh = {rxd_out, sh[7:2]};
        np = np + 1;
        if (np == 4) begin
          got_q.push_back(sh);
          np = 0;
        end
      end
      ph = (ph == (slow ? 9 : 0)) ? 0 : ph + 1;
    end else begin
      ph = 0;
      np = 0;
    end
  end
  task automatic send(input rpi_byte_t b[$], input bit err);
    for (int i = 0; i < b.size() * 4; i++) begin
      for (int k = 0; k < (slow ? 10 : 1); k++) begin
        @(posedge clk);
        tx_en_in <= 1'b1;
        txd_in <= b[i / 4][2 * (i % 4) +: 2];
        tx_err_in <= err && (i == 6);
      end
    end
    @(posedge clk);
    tx_en_in <= 1'b0;
    txd_in <= ~txd_in;
    tx_err_in <= 1'b0;
    @(posedge clk);
  endtask
endmodule // rpi_far_end

//--- sim/rmii_port_interface_tb_top.sv
// Purpose: Self-checking bench of the reduced interface port.
// Assumes: Far end is rpi_far_end; the bench drives the core streams.
// Notes: Expected bytes come from queues built here, never from the design.
`timescale 1ns/1ps

module rmii_port_interface_tb_top;
  import rpi_pkg::*;
  logic clk, sys_rst, ref_clock_drive_strap, freq_select_strap, speed_10_sel;
  logic half_duplex_sel, strap_error, crystal_input, crystal_output, ref_clock_output_pin;
  logic receive_valid_out, tx_en_in, tx_err_in, collision, stall, rx_done, coll_seen;
  logic mac_tx_valid, mac_tx_ready, mac_tx_last, mac_rx_valid, mac_rx_ready;
  logic mac_rx_last, mac_rx_err, rx_err;
  rpi_dibit_t rxd_out, txd_in;
  rpi_byte_t mac_tx_data, mac_rx_data;
  rpi_byte_t rx_q[$];
  logic refo_seen;
  int bad_count = 0;
  int samples_checked = 0;
  rmii_port_interface dut (.clk(clk), .sys_rst(sys_rst),
    .ref_clock_drive_strap(ref_clock_drive_strap), .freq_select_strap(freq_select_strap),
    .speed_10_sel(speed_10_sel), .half_duplex_sel(half_duplex_sel),
    .strap_error(strap_error), .crystal_input(crystal_input),
    .crystal_output(crystal_output), .ref_clock_output_pin(ref_clock_output_pin),
    .receive_valid_out(receive_valid_out), .rxd_out(rxd_out), .tx_en_in(tx_en_in),
    .txd_in(txd_in), .tx_err_in(tx_err_in), .mac_tx_valid(mac_tx_valid),
    .mac_tx_ready(mac_tx_ready), .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last),
    .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready), .mac_rx_data(mac_rx_data),
    .mac_rx_last(mac_rx_last), .mac_rx_err(mac_rx_err), .collision(collision));
  rpi_far_end fe (.clk(clk), .slow(speed_10_sel), .receive_valid_out(receive_valid_out),
    .rxd_out(rxd_out), .tx_en_in(tx_en_in), .txd_in(txd_in), .tx_err_in(tx_err_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Random ready stalls the ingress buffer; stall holds it off longer.
  always @(posedge clk) begin
    if (mac_rx_valid && mac_rx_ready) begin
      rx_q.push_back(mac_rx_data);
      rx_done = mac_rx_last;
      rx_err = mac_rx_err;
    end
    if (collision === 1'b1) coll_seen = 1'b1;
    mac_rx_ready <= !stall && ($urandom % 4 != 0);
    crystal_input <= 1'($urandom);
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic guard(input int w);
    if (w >= 3000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic cmp_byte(input rpi_byte_t e, input rpi_byte_t g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_bit(input logic e, input logic g);
    cmp_byte({7'h00, e}, {7'h00, g});
  endtask
  task automatic do_reset(input logic d, input logic f);
    @(posedge clk);
    sys_rst <= 1'b1;
    ref_clock_drive_strap <= d;
    freq_select_strap <= f;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic egress(input int n);
    rpi_byte_t q[$];
    int w;
    fe.got_q.delete();
    for (int i = 0; i < n; i++) q.push_back(rpi_byte_t'($urandom));
    foreach (q[i]) begin
      mac_tx_valid <= 1'b1;
      mac_tx_data <= q[i];
      mac_tx_last <= (i == n - 1);
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!mac_tx_ready && w < 3000);
      guard(w);
    end
    mac_tx_valid <= 1'b0;
    for (w = 0; w < 3000 && (fe.got_q.size() < n || receive_valid_out); w++) @(posedge clk);
    guard(w);
    foreach (q[i]) cmp_byte(q[i], fe.got_q[i]);
  endtask
  task automatic ingress(input int n, input bit e, input bit ovf);
    rpi_byte_t q[$];
    int w;
    q.push_back(8'h55);
    for (int i = 1; i < n; i++) q.push_back(rpi_byte_t'($urandom));
    rx_q.delete();
    rx_done = 1'b0;
    fe.send(q, e);
    stall = 1'b0;
    for (w = 0; w < 3000 && rx_done !== 1'b1; w++) @(posedge clk);
    guard(w);
    cmp_bit(e | ovf, rx_err);
    if (!ovf) foreach (q[i]) cmp_byte(q[i], rx_q[i]);
  endtask
  initial begin
    {sys_rst, ref_clock_drive_strap, freq_select_strap} = 3'h7;
    {speed_10_sel, half_duplex_sel, crystal_input, stall, coll_seen} = 5'h00;
    {mac_tx_valid, mac_tx_last, mac_rx_ready, rx_err, rx_done} = 5'h00;
    mac_tx_data = 8'h00;
    void'($urandom(32'h2833));
    do_reset(1'b1, 1'b1);
    @(negedge clk);
    refo_seen = ref_clock_output_pin;
    @(negedge clk);
    cmp_bit(!refo_seen, ref_clock_output_pin);
    @(posedge clk);
    for (int s = 0; s < 2; s++) begin
      speed_10_sel <= s[0];
      egress(6);
      ingress(6, 1'b0, 1'b0);
    end
    speed_10_sel <= 1'b0;
    ingress(5, 1'b1, 1'b0);
    half_duplex_sel <= 1'b1;
    fork
      egress(8);
      ingress(8, 1'b0, 1'b0);
    join
    cmp_bit(1'b1, coll_seen);
    stall = 1'b1;
    fork
      ingress(12, 1'b0, 1'b1);
      begin
        repeat (24) @(posedge clk);
        stall = 1'b0;
      end
    join
    do_reset(1'b1, 1'b0);
    cmp_bit(1'b1, strap_error);
    cmp_bit(1'b0, ref_clock_output_pin);
    do_reset(1'b0, 1'b0);
    cmp_bit(1'b0, strap_error);
    cmp_bit(1'b0, ref_clock_output_pin);
    tally_and_finish();
  end
endmodule // rmii_port_interface_tb_top
